//--- core/rcause_top.sv
// Functional notes
// - Bit 14 records an illegal opcode, address mode or uninitialised pointer reset.
// - Bit 12 selects the retention regulator in Sleep.
// - Bit 9 records a configuration word mismatch reset.
// - Bit 8 enables fast wake-up from Sleep.
// - Bit 7 records a master-clear pin reset.
// - Flags are software writable; writing one never causes a reset.
// - Unprogrammed regulator fuse keeps retention off in the wake sequencer regardless of bit 12; retention_active still follows bit 12.
// - Regulator re-enabled after standby adds a start-up delay on wake.
`timescale 1ns/1ns
`default_nettype none
module rcause_top
  import rcause_pkg::*;
#(
  parameter int DELAY_CYC = RCAUSE_REGULATOR_WAKE_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip events and power inputs.
  input  wire rcause_evt_t evt,
  input  wire logic        low_power_regulator_fuse,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  // Controls and status out.
  output logic             brownout_enable,
  output logic             sw_watchdog_enable,
  output logic             retention_active,
  output logic             fast_wake_enable,
  output logic             wake_done,
  output logic             irq
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] stat;
    logic [15:0] mask;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq;
    logic        wake;
  } rcause_state_t;

  rcause_state_t cur;
  rcause_state_t next_cur;
  logic [15:0]   evt_vec;
  logic          reg_off;
  logic          wake_pulse;
  logic          ret_eff;
  logic          acc;
  logic          wr;

  // Events mapped to their flag positions.
  always_comb begin
    evt_vec = 16'h0000;
    evt_vec[RCAUSE_B_TRAP]  = evt.trap;
    evt_vec[RCAUSE_B_ILLOP] = evt.illop;
    evt_vec[RCAUSE_B_CMIS]  = evt.cmis;
    evt_vec[RCAUSE_B_EXT]   = evt.ext;
    evt_vec[RCAUSE_B_SWR]   = evt.software_reset_flag;
    evt_vec[RCAUSE_B_WATCHDOG_TIMEOUT_FLAG]  = evt.watchdog_timeout_flag;
    evt_vec[RCAUSE_B_SLEEP] = evt.sleep;
    evt_vec[RCAUSE_B_IDLE]  = evt.idle;
    evt_vec[RCAUSE_B_BOR]   = evt.bor;
    evt_vec[RCAUSE_B_POR]   = evt.por;
  end

  // Retention applies only when the fuse is programmed (zero).
  assign ret_eff = cur.ctrl[RCAUSE_B_KEEP_ALIVE_REGULATOR_ENABLE] & ~low_power_regulator_fuse;
  assign acc = psel & penable & ~cur.ready;
  assign wr = acc & pwrite;

  // Wake sequencer.
  rcause_wake #(
    .DELAY_CYC(DELAY_CYC)
  ) u_wake (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .sleep_req      (sleep_req),
    .wake_req       (wake_req),
    .retention_on   (ret_eff),
    .fast_wake      (cur.ctrl[RCAUSE_B_FASTW]),
    .standby_reg_off(reg_off),
    .wake_done      (wake_pulse)
  );

  // Register writes, flag capture and APB answer; events win over clears.
  always_comb begin
    next_cur = cur;
    next_cur.ready = acc;
    next_cur.err = 1'b0;
    next_cur.wake = wake_pulse;
    if (wr) begin
      case (paddr)
        RCAUSE_OFF_CTRL: next_cur.ctrl = pwdata[15:0] & RCAUSE_CTRL_IMPL;
        RCAUSE_OFF_STAT: next_cur.stat = cur.stat & ~pwdata[15:0];
        RCAUSE_OFF_MASK: next_cur.mask = pwdata[15:0] & RCAUSE_EVENT_MASK;
        default:         next_cur.err = 1'b1;
      endcase
    end else if (acc) begin
      case (paddr)
        RCAUSE_OFF_CTRL: next_cur.rdata = {16'h0000, cur.ctrl};
        RCAUSE_OFF_STAT: next_cur.rdata = {16'h0000, cur.stat};
        RCAUSE_OFF_MASK: next_cur.rdata = {16'h0000, cur.mask};
        default: begin
          next_cur.rdata = 32'h0000_0000;
          next_cur.err = 1'b1;
        end
      endcase
    end
    next_cur.ctrl = next_cur.ctrl | evt_vec;
    next_cur.stat = next_cur.stat | evt_vec;
    next_cur.irq = |(next_cur.stat & cur.mask);
  end

  // State register; power-on value has brown-out and power-on flags set.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur <= '{ctrl: RCAUSE_CTRL_RESET, stat: 16'h0000, mask: 16'h0000,
               rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0, irq: 1'b0, wake: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = cur.rdata;
  assign pready = cur.ready;
  assign pslverr = cur.err;
  assign irq = cur.irq;
  assign wake_done = cur.wake;
  assign brownout_enable = cur.ctrl[RCAUSE_B_SW_BROWNOUT_ENABLE];
  assign sw_watchdog_enable = cur.ctrl[RCAUSE_B_SWDT];
  assign retention_active = cur.ctrl[RCAUSE_B_KEEP_ALIVE_REGULATOR_ENABLE];
  assign fast_wake_enable = cur.ctrl[RCAUSE_B_FASTW];

  // Checks.
  a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cur.ctrl[11:10] == 2'b00) else $error("unimplemented bits set");
  a_trap_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt.trap |=> cur.ctrl[RCAUSE_B_TRAP]) else $error("trap flag missed");
  a_illop_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt.illop |=> cur.ctrl[RCAUSE_B_ILLOP]) else $error("illop flag missed");
  a_cmis_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt.cmis |=> cur.ctrl[RCAUSE_B_CMIS]) else $error("mismatch flag missed");
  a_ext_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt.ext |=> cur.ctrl[RCAUSE_B_EXT]) else $error("pin flag missed");
  a_watchdog_timeout_flag_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    evt.watchdog_timeout_flag |=> cur.ctrl[RCAUSE_B_WATCHDOG_TIMEOUT_FLAG]) else $error("watchdog flag missed");
  a_fuse_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (low_power_regulator_fuse && sleep_req && u_wake.cur.st == RCAUSE_RUN) |=>
      reg_off == !$past(fast_wake_enable)) else $error("retention with fuse unprogrammed");
  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr && paddr == RCAUSE_OFF_CTRL && evt_vec == 16'h0000) |=>
      cur.ctrl == (16'($past(pwdata)) & RCAUSE_CTRL_IMPL)) else $error("ctrl write lost");
  a_fast_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sleep_req && u_wake.cur.st == RCAUSE_RUN && cur.ctrl[RCAUSE_B_FASTW] && !ret_eff) |=>
      !reg_off) else $error("fast wake mismatch");
  sequence s_off_wake;
    reg_off && u_wake.cur.st == RCAUSE_SLEEPING && wake_req;
  endsequence
  a_wake_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_off_wake |=> !wake_pulse) else $error("wake without regulator delay");
  a_sw_brownout_enable_reset: assert property (@(posedge clk_sys)
    !rst_n |=> cur.ctrl[RCAUSE_B_SW_BROWNOUT_ENABLE] && cur.ctrl[RCAUSE_B_BOR] && cur.ctrl[RCAUSE_B_POR])
    else $error("bad reset value");

endmodule
`default_nettype wire

//--- core/rcause_pkg.sv
package rcause_pkg;

  // Register map, one aligned word each.
  localparam logic [11:0] RCAUSE_OFF_CTRL = 12'h000;
  localparam logic [11:0] RCAUSE_OFF_STAT = 12'h004;
  localparam logic [11:0] RCAUSE_OFF_MASK = 12'h008;

  // Bit positions inside reset_cause_control.
  localparam int RCAUSE_B_TRAP   = 15;
  localparam int RCAUSE_B_ILLOP  = 14;
  localparam int RCAUSE_B_SW_BROWNOUT_ENABLE = 13;
  localparam int RCAUSE_B_KEEP_ALIVE_REGULATOR_ENABLE  = 12;
  localparam int RCAUSE_B_CMIS   = 9;
  localparam int RCAUSE_B_FASTW  = 8;
  localparam int RCAUSE_B_EXT    = 7;
  localparam int RCAUSE_B_SWR    = 6;
  localparam int RCAUSE_B_SWDT   = 5;
  localparam int RCAUSE_B_WATCHDOG_TIMEOUT_FLAG   = 4;
  localparam int RCAUSE_B_SLEEP  = 3;
  localparam int RCAUSE_B_IDLE   = 2;
  localparam int RCAUSE_B_BOR    = 1;
  localparam int RCAUSE_B_POR    = 0;

  // Value after power-on, and the bits that exist.
  localparam logic [15:0] RCAUSE_CTRL_RESET = 16'h2003;
  localparam logic [15:0] RCAUSE_CTRL_IMPL  = 16'hF3FF;
  // Bits that are events (flags); the other implemented bits are controls.
  localparam logic [15:0] RCAUSE_EVENT_MASK = 16'hC2DF;

  // Extra regulator start-up delay on wake.
  localparam int RCAUSE_REGULATOR_WAKE_DELAY_NS     = 10000;
  localparam int RCAUSE_CLK_PERIOD_NS = 100;
  localparam int RCAUSE_REGULATOR_WAKE_DELAY_CYC =
    (RCAUSE_REGULATOR_WAKE_DELAY_NS + RCAUSE_CLK_PERIOD_NS - 1) / RCAUSE_CLK_PERIOD_NS;

  // Reset-cause and power-state events from the rest of the chip.
  typedef struct packed {
    logic trap;
    logic illop;
    logic cmis;
    logic ext;
    logic software_reset_flag;
    logic watchdog_timeout_flag;
    logic sleep;
    logic idle;
    logic bor;
    logic por;
  } rcause_evt_t;

  // Wake sequencing states.
  typedef enum logic [1:0] {RCAUSE_RUN, RCAUSE_SLEEPING, RCAUSE_WAKE_WAIT} rcause_wst_t;

endpackage

//--- core/rcause_wake.sv
`timescale 1ns/1ns
`default_nettype none
// Sleep and wake sequencing with the optional regulator start-up delay.
module rcause_wake
  import rcause_pkg::*;
#(
  parameter int DELAY_CYC = RCAUSE_REGULATOR_WAKE_DELAY_CYC
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Control.
  input  wire logic sleep_req,
  input  wire logic wake_req,
  input  wire logic retention_on,
  input  wire logic fast_wake,
  // Status.
  output logic      standby_reg_off,
  output logic      wake_done
);

  typedef struct packed {
    rcause_wst_t st;
    logic [15:0] cnt;
    logic        reg_off;
    logic        done;
  } rcause_wstate_t;

  rcause_wstate_t cur;
  rcause_wstate_t next_cur;

  // Sleep entry turns the main regulator off unless fast wake is set and retention is off.
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    case (cur.st)
      RCAUSE_RUN: begin
        if (sleep_req) begin
          next_cur.st = RCAUSE_SLEEPING;
          next_cur.reg_off = retention_on | ~fast_wake;
        end
      end
      RCAUSE_SLEEPING: begin
        if (wake_req) begin
          if (cur.reg_off) begin
            next_cur.st = RCAUSE_WAKE_WAIT;
            next_cur.cnt = 16'(DELAY_CYC - 1);
          end else begin
            next_cur.st = RCAUSE_RUN;
            next_cur.done = 1'b1;
          end
        end
      end
      RCAUSE_WAKE_WAIT: begin
        if (cur.cnt == 16'h0000) begin
          next_cur.st = RCAUSE_RUN;
          next_cur.reg_off = 1'b0;
          next_cur.done = 1'b1;
        end else begin
          next_cur.cnt = cur.cnt - 16'h0001;
        end
      end
      default: next_cur.st = RCAUSE_RUN;
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur <= '{st: RCAUSE_RUN, cnt: 16'h0000, reg_off: 1'b0, done: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign standby_reg_off = cur.reg_off;
  assign wake_done = cur.done;

endmodule
`default_nettype wire

//--- sim/rcause_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rcause_top_tb
  import rcause_pkg::*;
;
  localparam int DC = 6;
  logic        clk_sys;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rcause_evt_t evt;
  logic        fuse;
  logic        sleep_req;
  logic        wake_req;
  logic        bo_en;
  logic        wd_en;
  logic        ret_act;
  logic        fw_en;
  logic        wake_done;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          check_count;
  int          n;
  int          pos [10] = '{0, 1, 2, 3, 4, 6, 7, 9, 14, 15};
  logic [2:0]  wk [4] = '{3'b100, 3'b101, 3'b001, 3'b000};
  logic [15:0] wc [4] = '{16'h1100, 16'h1000, 16'h1100, 16'h0100};

  rcause_top #(.DELAY_CYC(DC)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt(evt), .low_power_regulator_fuse(fuse), .sleep_req(sleep_req), .wake_req(wake_req),
    .brownout_enable(bo_en), .sw_watchdog_enable(wd_en), .retention_active(ret_act),
    .fast_wake_enable(fw_en), .wake_done(wake_done), .irq(irq)
  );

  // The clock runs at 10 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high at a rising edge.
  // Answers are looked at on the falling edge, where they are settled and equal to
  // what the next rising edge samples; the request is released at that rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(negedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("apb answer", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sleeps, wakes, and counts the cycles until wake completes.
  task automatic wake_run(output int c);
    @(posedge clk_sys); sleep_req <= 1'b1;
    @(posedge clk_sys); sleep_req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    wake_req <= 1'b1;
    @(posedge clk_sys); wake_req <= 1'b0;
    c = 0;
    // The pulse is looked at on the falling edge, while it stands.
    do begin
      @(negedge clk_sys);
      c++;
    end while (wake_done !== 1'b1 && c < 50);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #(100 * 5000);
    fails++;
    summarize();
  end

  // Main test sequence.
  initial begin
    fails = 0; check_count = 0;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    evt = '0; fuse = 1'b1; sleep_req = 1'b0; wake_req = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, RCAUSE_OFF_CTRL, '0);
    chk("ctrl reset", rd, 32'h0000_2003);
    chk("bo_en reset", {31'h0, bo_en}, 32'h1);
    apb(1'b1, RCAUSE_OFF_CTRL, 32'h0000_FFFF);
    apb(1'b0, RCAUSE_OFF_CTRL, '0);
    chk("ctrl all ones", rd, 32'h0000_F3FF);
    chk("ctrl outs set", {28'h0, bo_en, wd_en, ret_act, fw_en}, 32'hF);
    apb(1'b1, RCAUSE_OFF_CTRL, 32'h0000_0000);
    apb(1'b0, RCAUSE_OFF_CTRL, '0);
    chk("ctrl all zeros", rd, 32'h0);
    chk("ctrl outs clr", {28'h0, bo_en, wd_en, ret_act, fw_en}, 32'h0);
    // Each event alone sets its own flag.
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, RCAUSE_OFF_CTRL, 32'h0);
      @(posedge clk_sys); evt <= rcause_evt_t'(10'h001 << i);
      @(posedge clk_sys); evt <= '0;
      apb(1'b0, RCAUSE_OFF_CTRL, '0);
      chk("event flag", rd, 32'h1 << pos[i]);
    end
    apb(1'b0, RCAUSE_OFF_STAT, '0);
    chk("status all", rd, {16'h0, RCAUSE_EVENT_MASK});
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, RCAUSE_OFF_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'b1, RCAUSE_OFF_STAT, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, RCAUSE_OFF_STAT, '0);
    chk("status w1c", rd, {16'h0, RCAUSE_EVENT_MASK} & 32'hFFFE);
    apb(1'b0, 12'h00C, '0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    // Wake timing for fuse, retention and fast wake combinations.
    for (int j = 0; j < 4; j++) begin
      @(posedge clk_sys);
      fuse <= wk[j][2];
      apb(1'b1, RCAUSE_OFF_CTRL, {16'h0, wc[j]});
      wake_run(n);
      chk("wake cycles", n, wk[j][0] ? DC + 2 : 2);
      chk("wake seen", {31'h0, n < 50}, 32'h1);
    end
    // A second reset in mid-run brings back the power-on values.
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, RCAUSE_OFF_CTRL, '0);
    chk("ctrl rereset", rd, 32'h0000_2003);
    apb(1'b0, RCAUSE_OFF_STAT, '0);
    chk("status rereset", rd, 32'h0);
    chk("irq rereset", {31'h0, irq}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
